// ==== src/dvp_pkg.sv ====
// Constants, register map and carrier types for the second DAC pair control block.
// Assumes a 32-bit classic Wishbone master and a serial audio link of 32 slots per half frame.
package dvp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_UPDATE_CTRL = 6'h32;
    localparam logic [5:0] IDX_BOOST_MUTE = 6'h33;
    localparam logic [5:0] IDX_LEFT_ATT = 6'h34;
    localparam logic [5:0] IDX_RIGHT_ATT = 6'h35;
    localparam logic [5:0] IDX_ROLE_FMT = 6'h36;
    localparam logic [5:0] IDX_DEEMPH = 6'h37;
    localparam logic [5:0] IDX_STATUS = 6'h38;
    // Field positions
    localparam int UPD_SYNC_EN_BIT = 7;
    localparam int UPD_STROBE_R_BIT = 5;
    localparam int UPD_STROBE_L_BIT = 4;
    localparam int UPD_ZC_EN_BIT = 0;
    localparam int BM_BOOST_LSB = 2;
    localparam int BM_MUTE_R_BIT = 1;
    localparam int BM_MUTE_L_BIT = 0;
    localparam int CR_ROLE_LSB = 4;
    localparam int CR_FMT_LSB = 0;
    localparam int DE_EN_BIT = 3;
    localparam int DE_RATE_LSB = 0;
    localparam int ST_PEND_L_BIT = 0;
    localparam int ST_PEND_R_BIT = 1;
    localparam int ST_OVF_BIT = 2;
    localparam int ST_MASTER_BIT = 3;
    // Reset values and decode limits
    localparam logic RST_SYNC_EN = 1'b1;
    localparam logic [1:0] RST_BOOST = 2'h0;
    localparam logic [7:0] ATT_FULL = 8'hFF;
    localparam logic [7:0] ATT_MUTE_MAX = 8'h36;
    localparam logic [3:0] ROLE_SLAVE_AUTO = 4'h8;
    localparam logic [3:0] ROLE_MASTER_FIRST = 4'h1;
    localparam logic [3:0] ROLE_MASTER_LAST = 4'h6;
    localparam logic [1:0] RST_DEEMPH_RATE = 2'h0;
    // Zero-cross timeout in sample periods
    localparam int ZC_TIMEOUT_SAMPLES = 512;
    localparam logic [9:0] ZC_LAST = 10'(ZC_TIMEOUT_SAMPLES - 1);
    localparam logic [4:0] SLOT_LAST = 5'h1F;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    // Half bit-clock period in system clocks per master ratio code
    localparam logic [2:0] MASTER_HALF [8] = '{3'h0, 3'h6, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h0};
    // Gain mantissas for 0.5 dB steps within one 6 dB octave, unity = 2^16
    localparam logic [16:0] ATT_MANT [12] = '{17'h1_0000, 17'h0_F1AE, 17'h0_E429, 17'h0_D766,
        17'h0_CB59, 17'h0_BFF9, 17'h0_B53C, 17'h0_AB19, 17'h0_A186, 17'h0_987D, 17'h0_8FF6,
        17'h0_87E8};

    typedef enum logic [1:0] {
        FMT_I2S = 2'h0,
        FMT_LJ = 2'h1,
        FMT_RJ24 = 2'h2,
        FMT_RJ16 = 2'h3
    } dvp_fmt_t;

    typedef enum logic [1:0] {
        UPD_IDLE = 2'h0,
        UPD_WAIT = 2'h1
    } dvp_upd_t;

    typedef struct packed {
        logic mute;
        logic [7:0] atten;
    } dvp_level_t;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } dvp_frame_t;
endpackage

// ==== src/dvp_ctrl.sv ====
// Volume, mute, clock role and format control for the second DAC pair, with serial receiver.
// Assumes a classic Wishbone master on clk_i and an outside serial source on async pins.
// What this block does
// - With sync update and zero-cross enable both off, each written mute or level applies at once.
// - With sync update on, new levels wait for the channel's update strobe.
// - Update strobe bits clear themselves the cycle after being written.
// - After reset sync update reads 1 and both strobes read 0.
// - Zero-cross enable defers level changes to a zero crossing; resets to 0.
// - Without a zero crossing in 512 samples the pending change applies anyway.
// - Two-bit boost before attenuator: 0, 6, 12, 18 dB; resets to 0 dB.
// - A set mute bit forces that channel to zero; mute bits reset to 0.
// - Level code all-ones is 0 dB, 0.5 dB per step; 0x36 and below mute.
// - Both attenuation registers reset to all ones.
// - Slave takes frame sync and bit clock from outside; master generates both.
// - Clock role codes 1 to 6 decode as master; every other code, auto-detect 8 included, is slave.
// - Two-bit field selects I2S, left-justified, 24-bit or 16-bit right-justified.
// - De-emphasis enable, reset 0, switches the filter into the path.
// - De-emphasis rate: 00 44.1 kHz, 01 48 kHz, 10 32 kHz; resets 00.
//
// Our own choice: the Wishbone slave port.
module dvp_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic frame_sync_i,
    output logic frame_sync_o,
    output logic frame_sync_oe_o,
    input wire logic bit_clock_i,
    output logic bit_clock_o,
    output logic bit_clock_oe_o,
    input wire logic serial_data_i,
    output dvp_pkg::dvp_frame_t frame_o,
    output logic frame_valid_o,
    input wire logic frame_ready_i,
    output logic deemph_enable_o,
    output logic [1:0] deemph_rate_o
);
    function automatic logic is_master(input logic [3:0] role);
        return (role >= dvp_pkg::ROLE_MASTER_FIRST) && (role <= dvp_pkg::ROLE_MASTER_LAST);
    endfunction

    function automatic logic [23:0] boost_sat(input logic [23:0] s, input logic [1:0] sel);
        logic signed [26:0] w;
        w = 27'(signed'(s)) <<< sel;
        if (w > 27'sh07F_FFFF) begin
            boost_sat = 24'h7F_FFFF;
        end else if (w < 27'sh780_0000) begin
            boost_sat = 24'h80_0000;
        end else begin
            boost_sat = w[23:0];
        end
    endfunction

    function automatic logic [23:0] attenuate(input logic [23:0] s, input dvp_pkg::dvp_level_t lv);
        logic [7:0] k;
        logic [4:0] sh;
        logic [3:0] m;
        logic signed [41:0] p;
        k = dvp_pkg::ATT_FULL - lv.atten;
        sh = 5'(k / 8'h0C);
        m = 4'(k % 8'h0C);
        p = 42'(signed'(s)) * 42'(signed'({1'b0, dvp_pkg::ATT_MANT[m]}));
        p = p >>> (6'h10 + 6'(sh));
        if (lv.mute || lv.atten <= dvp_pkg::ATT_MUTE_MAX) begin
            attenuate = 24'h00_0000;
        end else begin
            attenuate = p[23:0];
        end
    endfunction

    // Bus and configuration state
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic sync_en_reg, sync_en_next;
    logic zc_en_reg, zc_en_next;
    logic [1:0] strb_reg, strb_next;
    logic [1:0] boost_reg, boost_next;
    dvp_pkg::dvp_level_t [1:0] shadow_reg, shadow_next;
    logic [3:0] role_reg, role_next;
    dvp_pkg::dvp_fmt_t fmt_reg, fmt_next;
    logic de_en_reg, de_en_next;
    logic [1:0] de_rate_reg, de_rate_next;
    logic ovf_reg, ovf_next;
    logic [5:0] idx;
    logic wr;
    logic [31:0] rd_val;
    logic [1:0] req;
    logic master;

    // Link state
    logic fs_s1_reg, fs_s2_reg, bc_s1_reg, bc_s2_reg, sd_s1_reg, sd_s2_reg;
    logic bc_d_reg, lr_prev_reg;
    logic bc_d_next, lr_prev_next;
    logic [31:0] sr_reg, sr_next;
    logic [23:0] left_hold_reg, left_hold_next;
    logic [2:0] div_reg, div_next;
    logic mbck_reg, mbck_next, mlrck_reg, mlrck_next;
    logic [4:0] slot_reg, slot_next;
    logic bck_rise, cap_valid, cap_left;
    logic [31:0] sr_in;
    logic [23:0] cap_word;

    // Update state
    dvp_pkg::dvp_upd_t [1:0] st_reg, st_next;
    logic [1:0][9:0] cnt_reg, cnt_next;
    dvp_pkg::dvp_level_t [1:0] act_reg, act_next;
    logic [1:0] sign_reg, sign_next;
    logic [1:0] ev, zc;

    // Output buffer
    dvp_pkg::dvp_frame_t fifo_mem [2];
    dvp_pkg::dvp_frame_t push_data;
    logic wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0] cnt_f_reg, cnt_f_next;
    logic push_valid, in_ready, push, pop;

    assign idx = wb_adr_i[7:2];
    // Write lands on the edge where the master sees ack
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
    assign master = is_master(role_reg);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (idx)
            dvp_pkg::IDX_UPDATE_CTRL: begin
                rd_val[dvp_pkg::UPD_SYNC_EN_BIT] = sync_en_reg;
                rd_val[dvp_pkg::UPD_STROBE_R_BIT] = strb_reg[1];
                rd_val[dvp_pkg::UPD_STROBE_L_BIT] = strb_reg[0];
                rd_val[dvp_pkg::UPD_ZC_EN_BIT] = zc_en_reg;
            end
            dvp_pkg::IDX_BOOST_MUTE: begin
                rd_val[dvp_pkg::BM_BOOST_LSB +: 2] = boost_reg;
                rd_val[dvp_pkg::BM_MUTE_R_BIT] = shadow_reg[1].mute;
                rd_val[dvp_pkg::BM_MUTE_L_BIT] = shadow_reg[0].mute;
            end
            dvp_pkg::IDX_LEFT_ATT: rd_val[7:0] = shadow_reg[0].atten;
            dvp_pkg::IDX_RIGHT_ATT: rd_val[7:0] = shadow_reg[1].atten;
            dvp_pkg::IDX_ROLE_FMT: begin
                rd_val[dvp_pkg::CR_ROLE_LSB +: 4] = role_reg;
                rd_val[dvp_pkg::CR_FMT_LSB +: 2] = fmt_reg;
            end
            dvp_pkg::IDX_DEEMPH: begin
                rd_val[dvp_pkg::DE_EN_BIT] = de_en_reg;
                rd_val[dvp_pkg::DE_RATE_LSB +: 2] = de_rate_reg;
            end
            dvp_pkg::IDX_STATUS: begin
                rd_val[dvp_pkg::ST_PEND_L_BIT] = (st_reg[0] == dvp_pkg::UPD_WAIT);
                rd_val[dvp_pkg::ST_PEND_R_BIT] = (st_reg[1] == dvp_pkg::UPD_WAIT);
                rd_val[dvp_pkg::ST_OVF_BIT] = ovf_reg;
                rd_val[dvp_pkg::ST_MASTER_BIT] = master;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        rdata_next = ack_next ? rd_val : rdata_reg;
        sync_en_next = sync_en_reg;
        zc_en_next = zc_en_reg;
        strb_next = 2'h0;
        boost_next = boost_reg;
        shadow_next = shadow_reg;
        role_next = role_reg;
        fmt_next = fmt_reg;
        de_en_next = de_en_reg;
        de_rate_next = de_rate_reg;
        ovf_next = ovf_reg;
        if (wr) begin
            case (idx)
                dvp_pkg::IDX_UPDATE_CTRL: begin
                    sync_en_next = wb_dat_i[dvp_pkg::UPD_SYNC_EN_BIT];
                    zc_en_next = wb_dat_i[dvp_pkg::UPD_ZC_EN_BIT];
                    strb_next[1] = wb_dat_i[dvp_pkg::UPD_STROBE_R_BIT];
                    strb_next[0] = wb_dat_i[dvp_pkg::UPD_STROBE_L_BIT];
                end
                dvp_pkg::IDX_BOOST_MUTE: begin
                    boost_next = wb_dat_i[dvp_pkg::BM_BOOST_LSB +: 2];
                    shadow_next[1].mute = wb_dat_i[dvp_pkg::BM_MUTE_R_BIT];
                    shadow_next[0].mute = wb_dat_i[dvp_pkg::BM_MUTE_L_BIT];
                end
                dvp_pkg::IDX_LEFT_ATT: shadow_next[0].atten = wb_dat_i[7:0];
                dvp_pkg::IDX_RIGHT_ATT: shadow_next[1].atten = wb_dat_i[7:0];
                dvp_pkg::IDX_ROLE_FMT: begin
                    role_next = wb_dat_i[dvp_pkg::CR_ROLE_LSB +: 4];
                    fmt_next = dvp_pkg::dvp_fmt_t'(wb_dat_i[dvp_pkg::CR_FMT_LSB +: 2]);
                end
                dvp_pkg::IDX_DEEMPH: begin
                    de_en_next = wb_dat_i[dvp_pkg::DE_EN_BIT];
                    de_rate_next = wb_dat_i[dvp_pkg::DE_RATE_LSB +: 2];
                end
                dvp_pkg::IDX_STATUS: begin
                    if (wb_dat_i[dvp_pkg::ST_OVF_BIT]) begin
                        ovf_next = 1'b0;
                    end
                end
                default: ovf_next = ovf_reg;
            endcase
        end
        // Overflow set beats a clear in the same cycle
        if (push_valid && !in_ready) begin
            ovf_next = 1'b1;
        end
    end

    // Strobe writes request only in sync mode; plain writes request otherwise
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            if (sync_en_reg) begin
                req[c] = wr && (idx == dvp_pkg::IDX_UPDATE_CTRL) &&
                    wb_dat_i[c == 0 ? dvp_pkg::UPD_STROBE_L_BIT : dvp_pkg::UPD_STROBE_R_BIT];
            end else begin
                req[c] = wr && ((idx == dvp_pkg::IDX_BOOST_MUTE) ||
                    (idx == (c == 0 ? dvp_pkg::IDX_LEFT_ATT : dvp_pkg::IDX_RIGHT_ATT)));
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            sync_en_reg <= dvp_pkg::RST_SYNC_EN;
            zc_en_reg <= 1'b0;
            strb_reg <= 2'h0;
            boost_reg <= dvp_pkg::RST_BOOST;
            shadow_reg <= {2{1'b0, dvp_pkg::ATT_FULL}};
            role_reg <= dvp_pkg::ROLE_SLAVE_AUTO;
            fmt_reg <= dvp_pkg::FMT_I2S;
            de_en_reg <= 1'b0;
            de_rate_reg <= dvp_pkg::RST_DEEMPH_RATE;
            ovf_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            sync_en_reg <= sync_en_next;
            zc_en_reg <= zc_en_next;
            strb_reg <= strb_next;
            boost_reg <= boost_next;
            shadow_reg <= shadow_next;
            role_reg <= role_next;
            fmt_reg <= fmt_next;
            de_en_reg <= de_en_next;
            de_rate_reg <= de_rate_next;
            ovf_reg <= ovf_next;
        end
    end

    // Master clocks feed the same synchroniser so data and edges stay aligned
    always_comb begin
        div_next = 3'h0;
        mbck_next = 1'b0;
        mlrck_next = 1'b0;
        slot_next = 5'h00;
        if (master) begin
            div_next = div_reg + 3'h1;
            mbck_next = mbck_reg;
            mlrck_next = mlrck_reg;
            slot_next = slot_reg;
            // Ratio 192 runs slightly fast: half periods are whole clocks
            if (div_reg >= dvp_pkg::MASTER_HALF[role_reg[2:0]] - 3'h1) begin
                div_next = 3'h0;
                mbck_next = !mbck_reg;
                if (mbck_reg) begin
                    slot_next = slot_reg + 5'h01;
                    if (slot_reg == dvp_pkg::SLOT_LAST) begin
                        mlrck_next = !mlrck_reg;
                    end
                end
            end
        end
    end

    assign bck_rise = bc_s2_reg && !bc_d_reg;
    assign sr_in = {sr_reg[30:0], sd_s2_reg};
    assign cap_valid = bck_rise && (fs_s2_reg != lr_prev_reg);
    assign cap_left = (fmt_reg == dvp_pkg::FMT_I2S) ? !lr_prev_reg : lr_prev_reg;

    always_comb begin
        case (fmt_reg)
            dvp_pkg::FMT_I2S: cap_word = sr_in[31:8];
            dvp_pkg::FMT_LJ: cap_word = sr_reg[31:8];
            dvp_pkg::FMT_RJ24: cap_word = sr_reg[23:0];
            dvp_pkg::FMT_RJ16: cap_word = {sr_reg[15:0], 8'h00};
            default: cap_word = sr_reg[31:8];
        endcase
    end

    always_comb begin
        bc_d_next = bc_s2_reg;
        sr_next = bck_rise ? sr_in : sr_reg;
        lr_prev_next = bck_rise ? fs_s2_reg : lr_prev_reg;
        left_hold_next = (cap_valid && cap_left) ? cap_word : left_hold_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fs_s1_reg <= 1'b0;
            fs_s2_reg <= 1'b0;
            bc_s1_reg <= 1'b0;
            bc_s2_reg <= 1'b0;
            sd_s1_reg <= 1'b0;
            sd_s2_reg <= 1'b0;
            bc_d_reg <= 1'b0;
            lr_prev_reg <= 1'b0;
            sr_reg <= 32'h0000_0000;
            left_hold_reg <= 24'h00_0000;
            div_reg <= 3'h0;
            mbck_reg <= 1'b0;
            mlrck_reg <= 1'b0;
            slot_reg <= 5'h00;
        end else begin
            fs_s1_reg <= master ? mlrck_reg : frame_sync_i;
            fs_s2_reg <= fs_s1_reg;
            bc_s1_reg <= master ? mbck_reg : bit_clock_i;
            bc_s2_reg <= bc_s1_reg;
            sd_s1_reg <= serial_data_i;
            sd_s2_reg <= sd_s1_reg;
            bc_d_reg <= bc_d_next;
            lr_prev_reg <= lr_prev_next;
            sr_reg <= sr_next;
            left_hold_reg <= left_hold_next;
            div_reg <= div_next;
            mbck_reg <= mbck_next;
            mlrck_reg <= mlrck_next;
            slot_reg <= slot_next;
        end
    end

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        act_next = act_reg;
        sign_next = sign_reg;
        for (int c = 0; c < 2; c++) begin
            ev[c] = cap_valid && (cap_left == (c == 0));
            zc[c] = ev[c] && ((cap_word[23] != sign_reg[c]) || (cap_word == 24'h00_0000));
            if (ev[c]) begin
                sign_next[c] = cap_word[23];
            end
            case (st_reg[c])
                dvp_pkg::UPD_IDLE: begin
                    if (req[c] && zc_en_reg) begin
                        st_next[c] = dvp_pkg::UPD_WAIT;
                        cnt_next[c] = 10'h000;
                    end else if (req[c]) begin
                        act_next[c] = shadow_next[c];
                    end
                end
                dvp_pkg::UPD_WAIT: begin
                    if (!zc_en_reg || zc[c] || (ev[c] && cnt_reg[c] == dvp_pkg::ZC_LAST)) begin
                        act_next[c] = shadow_reg[c];
                        st_next[c] = dvp_pkg::UPD_IDLE;
                    end else if (ev[c]) begin
                        cnt_next[c] = cnt_reg[c] + 10'h001;
                    end
                end
                default: st_next[c] = dvp_pkg::UPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg[0] <= dvp_pkg::UPD_IDLE;
            st_reg[1] <= dvp_pkg::UPD_IDLE;
            cnt_reg <= 20'h0_0000;
            act_reg <= {2{1'b0, dvp_pkg::ATT_FULL}};
            sign_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            act_reg <= act_next;
            sign_reg <= sign_next;
        end
    end

    // Frame leaves when the right word arrives; the serial side cannot stall
    assign push_valid = cap_valid && !cap_left;
    assign push_data = {attenuate(boost_sat(left_hold_reg, boost_reg), act_reg[0]),
        attenuate(boost_sat(cap_word, boost_reg), act_reg[1])};
    assign in_ready = (cnt_f_reg != dvp_pkg::FIFO_DEPTH);
    assign push = push_valid && in_ready;
    assign pop = frame_valid_o && frame_ready_i;

    always_comb begin
        wp_next = push ? !wp_reg : wp_reg;
        rp_next = pop ? !rp_reg : rp_reg;
        cnt_f_next = cnt_f_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_f_reg <= 2'h0;
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_f_reg <= cnt_f_next;
            if (push) begin
                fifo_mem[wp_reg] <= push_data;
            end
        end
    end

    assign frame_o = fifo_mem[rp_reg];
    assign frame_valid_o = (cnt_f_reg != 2'h0);
    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;
    assign bit_clock_o = mbck_reg;
    assign frame_sync_o = mlrck_reg;
    assign bit_clock_oe_o = master;
    assign frame_sync_oe_o = master;
    assign deemph_enable_o = de_en_reg;
    assign deemph_rate_o = de_rate_reg;

    default clocking cb @(posedge clk_i); endclocking

    sequence s_zc_req_l;
        req[0] && zc_en_reg && st_reg[0] == dvp_pkg::UPD_IDLE;
    endsequence
    sequence s_held_l;
        st_reg[0] == dvp_pkg::UPD_WAIT && $stable(act_reg[0]);
    endsequence

    AST_STROBE_SELF_CLEAR: assert property (disable iff (rst_i)
        (strb_reg != 2'h0) |=> (strb_reg == 2'h0) or ($past(wr) && $past(idx) == dvp_pkg::IDX_UPDATE_CTRL))
        else $error("Update strobe did not clear");
    AST_RESET_VALUES: assert property (disable iff (rst_i) $past(rst_i) |->
        sync_en_reg && strb_reg == 2'h0 && shadow_reg[0].atten == dvp_pkg::ATT_FULL)
        else $error("Reset values wrong");
    AST_IMMEDIATE_APPLY: assert property (disable iff (rst_i)
        (wr && idx == dvp_pkg::IDX_RIGHT_ATT && !sync_en_reg && !zc_en_reg &&
        st_reg[1] == dvp_pkg::UPD_IDLE) |=> act_reg[1].atten == $past(wb_dat_i[7:0]))
        else $error("Level not applied at once");
    AST_SYNC_HOLD: assert property (disable iff (rst_i)
        (sync_en_reg && !req[0] && st_reg[0] == dvp_pkg::UPD_IDLE) |=> $stable(act_reg[0]))
        else $error("Level changed without strobe");
    AST_ZC_DEFER: assert property (disable iff (rst_i)
        s_zc_req_l |=> s_held_l)
        else $error("Zero-cross change not deferred");
    AST_ZC_TIMEOUT: assert property (disable iff (rst_i)
        (st_reg[0] == dvp_pkg::UPD_WAIT && zc_en_reg && ev[0] && cnt_reg[0] == dvp_pkg::ZC_LAST)
        |=> st_reg[0] == dvp_pkg::UPD_IDLE && act_reg[0] == $past(shadow_reg[0]))
        else $error("Zero-cross timeout missed");
    AST_MUTE_ZERO: assert property (disable iff (rst_i)
        (push && act_reg[0].mute) |-> push_data.left == 24'h00_0000)
        else $error("Muted channel not zero");
    AST_MUTE_CODE: assert property (disable iff (rst_i)
        (push && act_reg[1].atten <= dvp_pkg::ATT_MUTE_MAX) |-> push_data.right == 24'h00_0000)
        else $error("Mute code not silent");
    AST_MASTER_DRIVE: assert property (disable iff (rst_i)
        !bit_clock_oe_o |=> !bit_clock_o && !frame_sync_o)
        else $error("Clock outputs active in slave role");
    AST_BOOST_SAT: assert property (disable iff (rst_i)
        (push && boost_reg == 2'h3 && !left_hold_reg[23] && left_hold_reg > 24'h0F_FFFF)
        |-> boost_sat(left_hold_reg, boost_reg) == 24'h7F_FFFF)
        else $error("Boost wrapped");
endmodule

// ==== verification/dvp_src.sv ====
// Serial audio source model: frame sync, bit clock and I2S data.
// Assumes the receiver samples data on the rising bit clock edge.
module dvp_src (
    output logic bclk_o,
    output logic fsync_o,
    output logic sdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bclk_o = 1'b0;
        fsync_o = 1'b1;
        sdata_o = 1'b0;
    end
    // Clock stands still between frames; trailing slot marks end of right half
    task automatic send(input logic [23:0] l, input logic [23:0] r);
        logic [63:0] w;
        w = {1'b0, l, 7'h00, 1'b0, r, 7'h00};
        // Step off the system clock edge to avoid sampling races
        #1;
        for (int i = 0; i < 65; i++) begin
            fsync_o = (i >= 32) && (i < 64);
            sdata_o = (i < 64) ? w[63 - i] : ~sdata_o;
            #40 bclk_o = 1'b1;
            #40 bclk_o = 1'b0;
        end
    endtask
endmodule

// ==== verification/tb_top.sv ====
// Register and frame tests for the second DAC pair control block.
// Assumes the serial source model and the classic Wishbone slave timing.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] L_SMP = 24'h12_3456;
    localparam logic [23:0] R_SMP = 24'hED_CBA9;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic frame_ready_i = 1'b0, fs, bc, sd, ack, fvld, de, fsoe, bcoe;
    logic bco, fso, b;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, dat;
    logic [1:0] dr;
    dvp_pkg::dvp_frame_t frm_o;
    int num_errors = 0, check_count = 0, cnt = 0;
    initial forever #5 clk_i = ~clk_i;
    dvp_src i_dvp_src (.bclk_o(bc), .fsync_o(fs), .sdata_o(sd));
    dvp_ctrl i_dvp_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(4'h1), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(dat), .wb_ack_o(ack), .frame_sync_i(fs), .frame_sync_o(fso),
        .frame_sync_oe_o(fsoe), .bit_clock_i(bc), .bit_clock_o(bco), .bit_clock_oe_o(bcoe),
        .serial_data_i(sd), .frame_o(frm_o), .frame_valid_o(fvld),
        .frame_ready_i(frame_ready_i), .deemph_enable_o(de), .deemph_rate_o(dr));
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, d, output logic [7:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            tally_and_finish;
        end
        q = dat[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk($sformatf("reg %h", a), 48'(e), 48'(q));
    endtask
    // Receiver stalls until the whole frame is in, then pops it
    task automatic frm(input logic [47:0] e);
        int n;
        n = 0;
        i_dvp_src.send(L_SMP, R_SMP);
        @(posedge clk_i);
        while (fvld !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 100) begin
            num_errors++;
            tally_and_finish;
        end
        chk("frame", e, frm_o);
        frame_ready_i <= 1'b1;
        @(posedge clk_i);
        frame_ready_i <= 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'hC8, 8'h80);
        rd(8'hCC, 8'h00);
        rd(8'hD0, 8'hFF);
        rd(8'hD4, 8'hFF);
        rd(8'hD8, 8'h80);
        rd(8'hDC, 8'h00);
        rd(8'hF0, 8'h00);
        frm({L_SMP, R_SMP});
        wr(8'hD0, 8'hF3);
        wr(8'hD4, 8'h36);
        frm({L_SMP, R_SMP});
        wr(8'hC8, 8'hB0);
        rd(8'hC8, 8'h80);
        frm({24'h09_1A2B, 24'h00_0000});
        wr(8'hC8, 8'h00);
        wr(8'hD4, 8'hFF);
        wr(8'hCC, 8'h01);
        frm({24'h00_0000, R_SMP});
        wr(8'hCC, 8'h04);
        frm({L_SMP, 24'hDB_9752});
        wr(8'hCC, 8'h0C);
        frm({24'h3F_FFFF, 24'h80_0000});
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h01);
        wr(8'hD0, 8'hFF);
        rd(8'hE0, 8'h01);
        frm({24'h09_1A2B, R_SMP});
        wr(8'hC8, 8'h00);
        rd(8'hE0, 8'h00);
        frm({L_SMP, R_SMP});
        wr(8'hDC, 8'h09);
        chk("deemph", 48'(3'h5), 48'({de, dr}));
        wr(8'hD8, 8'h43);
        chk("oe", 48'(2'h3), 48'({bcoe, fsoe}));
        b = bco;
        repeat (16) begin
            @(posedge clk_i);
            cnt = cnt + int'(bco != b);
            b = bco;
        end
        chk("bck toggles", 48'h8, 48'(cnt));
        cnt = 0;
        while (fso !== 1'b1 && cnt < 200) begin
            @(posedge clk_i);
            cnt++;
        end
        chk("fsync", 48'h1, 48'(fso));
        rd(8'hD8, 8'h43);
        wr(8'hD8, 8'h90);
        chk("oe", 48'(2'h0), 48'({bcoe, fsoe}));
        tally_and_finish;
    end
endmodule
